// >>> btrb_checker.sv
// Port assertions for the tuning register bank
`timescale 1ns/1ps
module btrb_checker
  import btrb_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Async reset
  input wire logic sda_oe_o, // Data pull-down enable
  input wire btrb_cfg_t cfg_o // Codes and decoded values
);
  localparam logic [10:0] GT [8] = '{11'h28A, 11'h302, 11'h352, 11'h398, 11'h3E8, 11'h438,
    11'h47E, 11'h4CE};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_vals;
    disable iff (1'b0) rst_i |-> cfg_o.freq_code == 5'h01 && cfg_o.gain1_code == 3'h4
      && cfg_o.gain2_code == 3'h4 && {cfg_o.ton1_code, cfg_o.ton2_code} == 6'h00
      && {cfg_o.ofs_en, cfg_o.ofs_pol, cfg_o.ofs_mag} == 6'h00 && !sda_oe_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");
  property p_ofs_off;
    $past(!cfg_o.ofs_en) && !cfg_o.ofs_en |-> cfg_o.ofs_ua == 5'h00;
  endproperty
  a_ofs_off: assert property (p_ofs_off) else $error("offset while disabled");
  property p_ofs_pos;
    cfg_o.ofs_en && cfg_o.ofs_pol && $stable(cfg_o.ofs_mag) && $past(cfg_o.ofs_en && cfg_o.ofs_pol)
      |-> cfg_o.ofs_ua == {1'b0, cfg_o.ofs_mag};
  endproperty
  a_ofs_pos: assert property (p_ofs_pos) else $error("bad sourced offset");
  property p_ofs_neg;
    cfg_o.ofs_en && !cfg_o.ofs_pol && $stable(cfg_o.ofs_mag)
      && $past(cfg_o.ofs_en && !cfg_o.ofs_pol) |-> cfg_o.ofs_ua == 5'h00 - {1'b0, cfg_o.ofs_mag};
  endproperty
  a_ofs_neg: assert property (p_ofs_neg) else $error("bad sunk offset");
  property p_freq;
    $stable(cfg_o.freq_code) |-> cfg_o.freq_khz == 11'h0FA + 11'h032
      * (cfg_o.freq_code > 5'h1B ? 11'h01B : 11'(cfg_o.freq_code));
  endproperty
  a_freq: assert property (p_freq) else $error("bad frequency decode");
  property p_gain1;
    $stable(cfg_o.gain1_code) |-> cfg_o.gain1_milli == GT[cfg_o.gain1_code];
  endproperty
  a_gain1: assert property (p_gain1) else $error("bad phase 1 gain");
  property p_gain2;
    $stable(cfg_o.gain2_code) |-> cfg_o.gain2_milli == GT[cfg_o.gain2_code];
  endproperty
  a_gain2: assert property (p_gain2) else $error("bad phase 2 gain");
  property p_ton1;
    $stable(cfg_o.ton1_code) |-> cfg_o.ton1_add_mv == 8'h1E * 8'(cfg_o.ton1_code);
  endproperty
  a_ton1: assert property (p_ton1) else $error("bad phase 1 on-time add");
  property p_ton2;
    $stable(cfg_o.ton2_code) |-> cfg_o.ton2_add_mv == 8'h1E * 8'(cfg_o.ton2_code);
  endproperty
  a_ton2: assert property (p_ton2) else $error("bad phase 2 on-time add");
endmodule

bind btrb_top btrb_checker chk_u (.core_clk_i, .rst_i, .sda_oe_o, .cfg_o);

// >>> btrb_defs.svh
// Register offsets, field positions, reset values and decode constants of the tuning bank
`ifndef BTRB_DEFS_SVH
`define BTRB_DEFS_SVH

// Bus address of this port (arbitrary value)
`define BTRB_I2C_ADDR 7'h2A

// Register offsets
`define BTRB_OFS_DC_OFFSET 8'h0E
`define BTRB_OFS_FREQ 8'h0F
`define BTRB_OFS_PH1_GAIN 8'h11
`define BTRB_OFS_PH1_OFFSET 8'h12
`define BTRB_OFS_PH2_GAIN 8'h13
`define BTRB_OFS_PH2_OFFSET 8'h14

// Field positions
`define BTRB_DC_EN_BIT 5
`define BTRB_DC_POL_BIT 4
`define BTRB_DC_MAG_MSB 3
`define BTRB_TON_MSB 6
`define BTRB_TON_LSB 4
`define BTRB_TRIM_MSB 3

// Reset values
`define BTRB_RST_DC_EN 1'h0
`define BTRB_RST_DC_POL 1'h0
`define BTRB_RST_DC_MAG 4'h0
`define BTRB_RST_FREQ 5'h01
`define BTRB_RST_GAIN 3'h4
`define BTRB_RST_TON 3'h0
`define BTRB_RST_FREQ_KHZ 11'h12C
`define BTRB_RST_GAIN_MILLI 11'h3E8
`define BTRB_RST_TON_MV 8'h00

// Decode constants
`define BTRB_FREQ_BASE_KHZ 11'h0FA
`define BTRB_FREQ_STEP_KHZ 11'h032
`define BTRB_FREQ_MAX_CODE 5'h1B
`define BTRB_TON_STEP_MV 8'h1E
`define BTRB_GAIN_0 11'h28A
`define BTRB_GAIN_1 11'h302
`define BTRB_GAIN_2 11'h352
`define BTRB_GAIN_3 11'h398
`define BTRB_GAIN_4 11'h3E8
`define BTRB_GAIN_5 11'h438
`define BTRB_GAIN_6 11'h47E
`define BTRB_GAIN_7 11'h4CE

`endif

// >>> btrb_host.sv
// Behavioural serial host that drives the programming port
`timescale 1ns/1ps
module btrb_host (
  input wire logic clk_i, // Core clock, paces the bus
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Serial clock, stands high when idle
  output logic sda_oe_o // High pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Quarter bit of 4 cycles keeps each phase well above the sync latency
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_oe_o = 1'b1;
    w(8);
    scl_o = 1'b0;
    w(4);
  endtask
  task automatic rstart();
    sda_oe_o = 1'b0;
    w(4);
    scl_o = 1'b1;
    w(8);
    start();
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_oe_o = 1'b0;
    w(8);
  endtask
  task automatic bit1(input logic b, output logic r);
    sda_oe_o = ~b;
    w(4);
    scl_o = 1'b1;
    w(4);
    r = sda_i;
    w(4);
    scl_o = 1'b0;
    w(4);
  endtask
  task automatic xb(input logic [7:0] d, input logic a9, output logic [7:0] q, output logic r9);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r);
      q[i] = r;
    end
    bit1(a9, r9);
  endtask
endmodule

// >>> btrb_pin_cond.sv
// Pin synchronisers and start, stop and clock edge detection for the programming port
`timescale 1ns/1ps
`include "btrb_defs.svh"
module btrb_pin_cond
  import btrb_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Async reset, active high
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin level
  input wire logic [3:0] trim1_i, // Phase 1 trim fuses
  input wire logic [3:0] trim2_i, // Phase 2 trim fuses
  output btrb_pins_t pins_o // Conditioned events
);

  btrb_cond_st_t q;
  btrb_cond_st_t d;

  always_comb begin
    d = q;
    d.scl_m = scl_i;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.trim_m = {trim2_i, trim1_i};
    d.trim_s = q.trim_m;
    // Edges judged on synchronised copies only
    d.ev.rise = q.scl_s & ~q.scl_p;
    d.ev.fall = ~q.scl_s & q.scl_p;
    d.ev.start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    d.ev.stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    d.ev.sda = q.sda_s;
    d.ev.trim1 = q.trim_s[3:0];
    d.ev.trim2 = q.trim_s[7:4];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.ev.sda <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pins_o = q.ev;

endmodule

// >>> btrb_pkg.sv
// Types shared by the tuning bank modules
package btrb_pkg;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_PTR   = 3'b010,
    S_WDATA = 3'b011,
    S_ACK   = 3'b100,
    S_RDATA = 3'b101,
    S_RACK  = 3'b110
  } btrb_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
    logic [3:0] trim1;
    logic [3:0] trim2;
  } btrb_pins_t;

  typedef struct packed {
    logic ofs_en;
    logic ofs_pol;
    logic [3:0] ofs_mag;
    logic signed [4:0] ofs_ua;
    logic [4:0] freq_code;
    logic [10:0] freq_khz;
    logic [2:0] gain1_code;
    logic [10:0] gain1_milli;
    logic [2:0] ton1_code;
    logic [7:0] ton1_add_mv;
    logic [2:0] gain2_code;
    logic [10:0] gain2_milli;
    logic [2:0] ton2_code;
    logic [7:0] ton2_add_mv;
  } btrb_cfg_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [7:0] trim_m;
    logic [7:0] trim_s;
    btrb_pins_t ev;
  } btrb_cond_st_t;

  typedef struct packed {
    btrb_state_t st;
    btrb_state_t ack_to;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic mack;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    btrb_cfg_t cfg;
  } btrb_top_st_t;

endpackage

// >>> btrb_top.sv
// Buck tuning register bank with its serial programming port
//
// Behaviour
// - Offset current applies only while offset enable bit is set; resets disabled.
// - Offset polarity bit: 0 sinks (negative), 1 sources (positive); resets 0.
// - Offset magnitude bits 3:0 give 0 to 15 microamperes; resets to zero.
// - Five-bit frequency code: 250kHz plus 50kHz per step up to code 27 (1600kHz); resets to 300kHz.
// - Phase 1 balance gain: eight codes from 0.65x to 1.23x; resets unity.
// - Phase 2 balance gain uses the same eight-step mapping; resets unity.
// - Phase 1 on-time offset bits 6:4 add code times 30mV; resets zero.
// - Phase 2 on-time offset bits 6:4, same 30mV step; resets zero.
// - Phase 1 offset register bits 3:0 read back the factory trim.
// - Phase 2 offset register bits 3:0 read back the factory trim.
`timescale 1ns/1ps
`include "btrb_defs.svh"
module btrb_top
  import btrb_pkg::*;
(
  input wire logic core_clk_i, // 40 MHz core clock
  input wire logic rst_i, // Async reset, active high
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin level
  input wire logic [3:0] trim1_i, // Phase 1 factory trim
  input wire logic [3:0] trim2_i, // Phase 2 factory trim
  output logic sda_out_o, // Data pin drive value, always low
  output logic sda_oe_o, // Data pin pull-down enable
  output btrb_cfg_t cfg_o // Codes and decoded values for the loop
);

  btrb_pins_t p;
  btrb_top_st_t q;
  btrb_top_st_t d;
  logic [7:0] rb;

  btrb_pin_cond u_pin_cond (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .trim1_i(trim1_i),
    .trim2_i(trim2_i),
    .pins_o(p)
  );

  // Gain in thousandths
  function automatic logic [10:0] gain_milli_f(input logic [2:0] code);
    logic [10:0] g;
    unique case (code)
      3'h0: g = `BTRB_GAIN_0;
      3'h1: g = `BTRB_GAIN_1;
      3'h2: g = `BTRB_GAIN_2;
      3'h3: g = `BTRB_GAIN_3;
      3'h4: g = `BTRB_GAIN_4;
      3'h5: g = `BTRB_GAIN_5;
      3'h6: g = `BTRB_GAIN_6;
      3'h7: g = `BTRB_GAIN_7;
    endcase
    return g;
  endfunction

  // Numerator of the added on-time, divided by reference_input_voltage downstream
  function automatic logic [7:0] ton_mv_f(input logic [2:0] code);
    logic [7:0] m;
    m = 8'({5'h00, code} * `BTRB_TON_STEP_MV);
    return m;
  endfunction

  // Codes past the last listed entry fall back to it
  function automatic logic [10:0] freq_khz_f(input logic [4:0] code);
    logic [4:0] c;
    logic [10:0] f;
    c = (code > `BTRB_FREQ_MAX_CODE) ? `BTRB_FREQ_MAX_CODE : code;
    f = `BTRB_FREQ_BASE_KHZ + 11'({6'h00, c} * `BTRB_FREQ_STEP_KHZ);
    return f;
  endfunction

  function automatic logic [7:0] rd_byte_f(input logic [7:0] adr, input btrb_cfg_t c,
                                           input logic [3:0] t1, input logic [3:0] t2);
    logic [7:0] r;
    r = 8'h00;
    unique case (adr)
      `BTRB_OFS_DC_OFFSET: r = {2'h0, c.ofs_en, c.ofs_pol, c.ofs_mag};
      `BTRB_OFS_FREQ: r = {3'h0, c.freq_code};
      `BTRB_OFS_PH1_GAIN: r = {5'h00, c.gain1_code};
      `BTRB_OFS_PH1_OFFSET: r = {1'h0, c.ton1_code, t1};
      `BTRB_OFS_PH2_GAIN: r = {5'h00, c.gain2_code};
      `BTRB_OFS_PH2_OFFSET: r = {1'h0, c.ton2_code, t2};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  always_comb begin
    d = q;
    rb = rd_byte_f(q.ptr, q.cfg, p.trim1, p.trim2);
    // Decoded values trail a write by one cycle; the loop sees static codes anyway
    if (q.cfg.ofs_en) begin
      if (q.cfg.ofs_pol) begin
        d.cfg.ofs_ua = $signed({1'b0, q.cfg.ofs_mag});
      end else begin
        d.cfg.ofs_ua = -$signed({1'b0, q.cfg.ofs_mag});
      end
    end else begin
      d.cfg.ofs_ua = 5'sh00;
    end
    d.cfg.freq_khz = freq_khz_f(q.cfg.freq_code);
    d.cfg.gain1_milli = gain_milli_f(q.cfg.gain1_code);
    d.cfg.gain2_milli = gain_milli_f(q.cfg.gain2_code);
    d.cfg.ton1_add_mv = ton_mv_f(q.cfg.ton1_code);
    d.cfg.ton2_add_mv = ton_mv_f(q.cfg.ton2_code);
    d.sda_out = 1'b0;

    if (p.stop) begin
      d.st = S_IDLE;
      d.sda_oe = 1'b0;
    end else if (p.start) begin
      // Repeated start keeps the pointer, so a read follows a pointer write
      d.st = S_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        S_IDLE: begin
          d.sda_oe = 1'b0;
        end
        S_ADDR, S_PTR, S_WDATA: begin
          if (p.rise && q.cnt < 4'h8) begin
            d.sh = {q.sh[6:0], p.sda};
            d.cnt = q.cnt + 4'h1;
          end else if (p.fall && q.cnt == 4'h8) begin
            d.cnt = 4'h0;
            d.sda_oe = 1'b1;
            d.st = S_ACK;
            if (q.st == S_ADDR) begin
              if (q.sh[7:1] == `BTRB_I2C_ADDR) begin
                d.ack_to = q.sh[0] ? S_RDATA : S_PTR;
              end else begin
                // Not our address: stay off the bus until the next start
                d.sda_oe = 1'b0;
                d.st = S_IDLE;
              end
            end else if (q.st == S_PTR) begin
              d.ptr = q.sh;
              d.ack_to = S_WDATA;
            end else begin
              d.ptr = q.ptr + 8'h01;
              d.ack_to = S_WDATA;
              unique case (q.ptr)
                `BTRB_OFS_DC_OFFSET: begin
                  d.cfg.ofs_en = q.sh[`BTRB_DC_EN_BIT];
                  d.cfg.ofs_pol = q.sh[`BTRB_DC_POL_BIT];
                  d.cfg.ofs_mag = q.sh[`BTRB_DC_MAG_MSB:0];
                end
                `BTRB_OFS_FREQ: d.cfg.freq_code = q.sh[4:0];
                `BTRB_OFS_PH1_GAIN: d.cfg.gain1_code = q.sh[2:0];
                `BTRB_OFS_PH1_OFFSET: begin
                  // Trim bits have no storage here, so a write cannot reach them
                  d.cfg.ton1_code = q.sh[`BTRB_TON_MSB:`BTRB_TON_LSB];
                end
                `BTRB_OFS_PH2_GAIN: d.cfg.gain2_code = q.sh[2:0];
                `BTRB_OFS_PH2_OFFSET: begin
                  d.cfg.ton2_code = q.sh[`BTRB_TON_MSB:`BTRB_TON_LSB];
                end
                default: d.cfg = d.cfg;
              endcase
            end
          end
        end
        S_ACK: begin
          if (p.fall) begin
            d.cnt = 4'h0;
            if (q.ack_to == S_RDATA) begin
              d.sh = rb;
              d.sda_oe = ~rb[7];
              d.st = S_RDATA;
            end else begin
              d.sda_oe = 1'b0;
              d.st = q.ack_to;
            end
          end
        end
        S_RDATA: begin
          if (p.fall) begin
            if (q.cnt == 4'h7) begin
              d.sda_oe = 1'b0;
              d.ptr = q.ptr + 8'h01;
              d.st = S_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (p.rise) begin
            d.mack = ~p.sda;
          end else if (p.fall) begin
            d.cnt = 4'h0;
            if (q.mack) begin
              d.sh = rb;
              d.sda_oe = ~rb[7];
              d.st = S_RDATA;
            end else begin
              d.st = S_IDLE;
            end
          end
        end
        default: begin
          d.st = S_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg.ofs_en <= `BTRB_RST_DC_EN;
      q.cfg.ofs_pol <= `BTRB_RST_DC_POL;
      q.cfg.ofs_mag <= `BTRB_RST_DC_MAG;
      q.cfg.freq_code <= `BTRB_RST_FREQ;
      q.cfg.freq_khz <= `BTRB_RST_FREQ_KHZ;
      q.cfg.gain1_code <= `BTRB_RST_GAIN;
      q.cfg.gain1_milli <= `BTRB_RST_GAIN_MILLI;
      q.cfg.gain2_code <= `BTRB_RST_GAIN;
      q.cfg.gain2_milli <= `BTRB_RST_GAIN_MILLI;
      q.cfg.ton1_code <= `BTRB_RST_TON;
      q.cfg.ton1_add_mv <= `BTRB_RST_TON_MV;
      q.cfg.ton2_code <= `BTRB_RST_TON;
      q.cfg.ton2_add_mv <= `BTRB_RST_TON_MV;
    end else begin
      q <= d;
    end
  end

  assign sda_out_o = q.sda_out;
  assign sda_oe_o = q.sda_oe;
  assign cfg_o = q.cfg;

endmodule

// >>> tb.sv
// Self-checking testbench of the tuning register bank
`timescale 1ns/1ps
`include "btrb_defs.svh"
`define CK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb
  import btrb_pkg::*;
();
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic [3:0] trim1_i = 4'hA;
  logic [3:0] trim2_i = 4'h5;
  logic scl;
  logic host_oe;
  logic sda_oe;
  logic sda_out;
  btrb_cfg_t cfg;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [10:0] GT [8] = '{11'h28A, 11'h302, 11'h352, 11'h398, 11'h3E8, 11'h438,
    11'h47E, 11'h4CE};
  localparam logic [4:0] FC [5] = '{5'h00, 5'h05, 5'h09, 5'h17, 5'h1B};
  // Open drain with pull-up: low while either side pulls; a high drive value breaks every ack
  wire logic sda = ~(host_oe | (sda_oe & ~sda_out));
  btrb_top dut_u (.core_clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .trim1_i, .trim2_i,
    .sda_out_o(sda_out), .sda_oe_o(sda_oe), .cfg_o(cfg));
  btrb_host host_u (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  task automatic sb(input logic [7:0] d);
    logic [7:0] q;
    logic r;
    host_u.xb(d, 1'b1, q, r);
    `CK("ack", 1'b0, r)
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n);
    host_u.start();
    sb({`BTRB_I2C_ADDR, 1'b0});
    sb(a);
    for (int k = 0; k < n; k++) sb(d[8*(n-1-k) +: 8]);
    host_u.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] q;
    logic r;
    host_u.start();
    sb({`BTRB_I2C_ADDR, 1'b0});
    sb(a);
    host_u.rstart();
    sb({`BTRB_I2C_ADDR, 1'b1});
    host_u.xb(8'hFF, 1'b1, q, r);
    host_u.stop();
    `CK("rdata", ex, q)
  endtask
  task automatic t_reset();
    rd(8'h0E, 8'h00);
    rd(8'h0F, 8'h01);
    rd(8'h11, 8'h04);
    rd(8'h12, {4'h0, trim1_i});
    rd(8'h13, 8'h04);
    rd(8'h14, {4'h0, trim2_i});
    rd(8'h10, 8'h00);
    `CK("ua", 5'h00, cfg.ofs_ua)
    `CK("khz", 11'h12C, cfg.freq_khz)
  endtask
  task automatic t_offset();
    logic [5:0] v;
    logic [4:0] ua;
    for (int i = 0; i < 5; i++) begin
      v = (i < 4) ? {i[1:0], 4'hF} : 6'h35;
      ua = {1'b0, v[3:0]};
      wr(8'h0E, 24'(v), 1);
      `CK("en", v[5], cfg.ofs_en)
      `CK("pol", v[4], cfg.ofs_pol)
      `CK("ua", v[5] ? (v[4] ? ua : 5'h00 - ua) : 5'h00, cfg.ofs_ua)
    end
    rd(8'h0E, 8'h35);
  endtask
  task automatic t_freq();
    for (int i = 0; i < 5; i++) begin
      wr(8'h0F, 24'(FC[i]), 1);
      `CK("khz", 11'h0FA + 11'h032 * 11'(FC[i]), cfg.freq_khz)
    end
    rd(8'h0F, 8'h1B);
  endtask
  // Gain, on-time and gain in one burst exercises pointer increment
  task automatic t_gain();
    logic [2:0] c;
    logic [2:0] nc;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      nc = ~c;
      wr(8'h11, {5'h00, c, 1'b0, nc, 4'hF, 5'h00, nc}, 3);
      `CK("gain1", GT[c], cfg.gain1_milli)
      `CK("gain2", GT[nc], cfg.gain2_milli)
      `CK("ton1", 8'h1E * 8'(nc), cfg.ton1_add_mv)
      rd(8'h12, {1'b0, nc, trim1_i});
    end
  endtask
  task automatic t_ton2();
    wr(8'h14, 24'h00003A, 1);
    `CK("ton2", 8'h5A, cfg.ton2_add_mv)
    trim2_i = 4'hC;
    rd(8'h14, 8'h3C);
  endtask
  // Master ack carries a read on to the next register; a foreign address gets no ack
  task automatic t_burst();
    logic [7:0] q;
    logic r;
    host_u.start();
    sb({`BTRB_I2C_ADDR, 1'b0});
    sb(8'h11);
    host_u.rstart();
    sb({`BTRB_I2C_ADDR, 1'b1});
    host_u.xb(8'hFF, 1'b0, q, r);
    `CK("burst0", 8'h07, q)
    host_u.xb(8'hFF, 1'b1, q, r);
    `CK("burst1", {4'h0, trim1_i}, q)
    host_u.stop();
    host_u.start();
    host_u.xb({`BTRB_I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, q, r);
    `CK("nack", 1'b1, r)
    host_u.stop();
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    #1 rst_i = 1'b1;
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1;
    t_reset();
    t_offset();
    t_freq();
    t_gain();
    t_ton2();
    t_burst();
    // Reset in mid-run must bring every written field back
    rst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1;
    t_reset();
    results();
  end
endmodule
